// ===== tlp_tx_source.sv
// application-side source of whole TLPs into the transmit stream
`timescale 1ns/1ps
`default_nettype none
module tlp_tx_source
  import tlp_tx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wide_mode,
  input wire logic lat_two,
  input wire logic pkt_start,
  input wire logic [LEN_W-1:0] pkt_beats,
  input wire logic pkt_last_half,
  output logic pkt_busy,
  input wire logic beat_avail,
  input wire logic [WORD_W-1:0] beat_data,
  output logic beat_take,
  output logic pkt_done,
  input wire logic tx_accept_ok,
  input wire logic core_reset_status,
  output logic [WORD_W-1:0] tx_word_bus,
  output logic tx_first_beat,
  output logic tx_last_beat,
  output logic tx_beat_qualifier,
  output logic tx_upper_half_unused
);
  src_state_e state_reg, state_next;
  logic [LEN_W-1:0] left_reg, left_next;
  logic [1:0] hold_reg;
  logic half_reg, first_reg;
  logic acc_s1_reg, acc_s2_reg;
  logic rst_s1_reg, rst_s2_reg;
  logic [WORD_W-1:0] word_reg;
  logic first_out_reg, last_out_reg, valid_reg, empty_reg;
  logic take_reg, done_reg, busy_reg;
  logic ready_cycle;

  // pin inputs from the core pass two flops first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_s1_reg <= 1'b0;
      acc_s2_reg <= 1'b0;
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
    end else begin
      acc_s1_reg <= tx_accept_ok;
      acc_s2_reg <= acc_s1_reg;
      rst_s1_reg <= core_reset_status;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  ready_delay u_ready_delay (
    .sys_clk(sys_clk),
    .reset(reset),
    .lat_two(lat_two),
    .ready_in(acc_s2_reg),
    .ready_cycle(ready_cycle)
  );

  // ready alone cannot start a packet: core must be out of reset too
  wire core_up = !rst_s2_reg;
  wire holdoff_done = (hold_reg == RESET_HOLDOFF);
  wire can_start = holdoff_done && core_up && pkt_start;
  wire sending = (state_reg == ST_SEND);
  // a beat goes out only in a granted cycle with data on hand
  wire send_beat = sending && ready_cycle && beat_avail;
  wire last_beat = (left_reg == LEN_ONE);
  wire zero_len = (pkt_beats == '0);

  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    case (state_reg)
      ST_IDLE: begin
        // zero length would be malformed; never started
        if (can_start && !zero_len) begin
          state_next = ST_SEND;
          left_next = pkt_beats;
        end
      end
      ST_SEND: begin
        if (send_beat) begin
          left_next = left_reg - LEN_ONE;
          if (last_beat) begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      left_reg <= '0;
      hold_reg <= '0;
      half_reg <= 1'b0;
      first_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
      if (!holdoff_done) begin
        hold_reg <= hold_reg + 2'h1;
      end
      if (state_reg == ST_IDLE && state_next == ST_SEND) begin
        half_reg <= pkt_last_half && wide_mode;
        first_reg <= 1'b1;
      end else if (send_beat) begin
        first_reg <= 1'b0;
      end
    end
  end

  // output stage; valid clears whenever no beat is granted
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      word_reg <= '0;
      first_out_reg <= 1'b0;
      last_out_reg <= 1'b0;
      valid_reg <= 1'b0;
      empty_reg <= 1'b0;
      take_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      valid_reg <= send_beat;
      take_reg <= send_beat;
      first_out_reg <= send_beat && first_reg;
      last_out_reg <= send_beat && last_beat;
      // in 64-bit mode the upper half flag stays low
      empty_reg <= send_beat && last_beat && half_reg;
      done_reg <= send_beat && last_beat;
      busy_reg <= (state_next != ST_IDLE) || !holdoff_done;
      if (send_beat) begin
        // 64-bit mode leaves the upper half zero
        word_reg <= wide_mode ? beat_data :
          {{(WORD_W-QWORD_W){1'b0}}, beat_data[QWORD_W-1:0]};
      end
    end
  end

  // message and header layout is the caller's; words pass unchanged in 128-bit mode, 64-bit mode zeroes the upper half
  assign tx_word_bus = word_reg;
  assign tx_first_beat = first_out_reg;
  assign tx_last_beat = last_out_reg;
  assign tx_beat_qualifier = valid_reg;
  assign tx_upper_half_unused = empty_reg;
  assign beat_take = take_reg;
  assign pkt_done = done_reg;
  assign pkt_busy = busy_reg;

  // a miscounted packet would hang the sink; counting prevents it
  a_valid_granted: assert property (@(posedge sys_clk) disable iff (reset)
    tx_beat_qualifier |-> $past(ready_cycle))
    else $error("valid without granted ready cycle");
  a_first_has_valid: assert property (@(posedge sys_clk) disable iff (reset)
    tx_first_beat |-> tx_beat_qualifier)
    else $error("first marker without valid");
  a_last_has_valid: assert property (@(posedge sys_clk) disable iff (reset)
    tx_last_beat |-> tx_beat_qualifier)
    else $error("last marker without valid");
  a_empty_on_last: assert property (@(posedge sys_clk) disable iff (reset)
    tx_upper_half_unused |-> tx_last_beat && wide_mode)
    else $error("upper half flag off last beat");
  a_no_early_start: assert property (@(posedge sys_clk) disable iff (reset)
    tx_first_beat |-> holdoff_done)
    else $error("packet before reset holdoff");
  a_drop_valid: assert property (@(posedge sys_clk) disable iff (reset)
    !acc_s2_reg ##1 !acc_s2_reg ##1 !acc_s2_reg |=> !tx_beat_qualifier)
    else $error("valid held after ready fell");
  a_beats_counted: assert property (@(posedge sys_clk) disable iff (reset)
    send_beat && last_beat |=> state_reg == ST_DONE)
    else $error("packet end missed");
  a_one_packet: assert property (@(posedge sys_clk) disable iff (reset)
    tx_first_beat && !tx_last_beat |=> !tx_first_beat)
    else $error("new start inside packet");
  a_core_up: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(sending) |-> $past(core_up))
    else $error("start while core in reset");
  c_single_beat: cover property (@(posedge sys_clk) disable iff (reset)
    tx_first_beat && tx_last_beat);
  c_multi_beat: cover property (@(posedge sys_clk) disable iff (reset)
    tx_first_beat ##[1:20] tx_last_beat);
  c_stall: cover property (@(posedge sys_clk) disable iff (reset)
    sending && !ready_cycle ##1 send_beat);
  c_half_unused: cover property (@(posedge sys_clk) disable iff (reset)
    tx_upper_half_unused);
endmodule : tlp_tx_source
`default_nettype wire

// ===== tlp_tx_pkg.sv
// shared constants for the transmit stream source
package tlp_tx_pkg;
  localparam int WORD_W = 128;
  localparam int QWORD_W = 64;
  localparam int LEN_W = 10;
  localparam int READY_LATENCY = 2;
  localparam logic [1:0] LAT_ONE = 2'h1;
  localparam logic [1:0] LAT_TWO = 2'h2;
  localparam logic [1:0] RESET_HOLDOFF = 2'h2;
  localparam logic [1:0] PIPE_DEPTH = 2'h2;
  localparam logic [LEN_W-1:0] LEN_ONE = 10'h001;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b11
  } src_state_e;
endpackage : tlp_tx_pkg

// ===== ready_delay.sv
// delays the sink's ready by the configured ready latency
`timescale 1ns/1ps
`default_nettype none
module ready_delay
  import tlp_tx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic lat_two,
  input wire logic ready_in,
  output logic ready_cycle
);
  logic [PIPE_DEPTH-1:0] pipe_reg;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= {pipe_reg[0], ready_in};
    end
  end
  // ready in cycle n grants cycle n plus latency
  assign ready_cycle = lat_two ? pipe_reg[1] : pipe_reg[0];
endmodule : ready_delay
`default_nettype wire

// ===== sink_model.sv
// behavioural transaction-layer sink facing the TLP source
`timescale 1ns/1ps
`default_nettype none
module sink_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic valid,
  input wire logic first,
  input wire logic last,
  output logic ready,
  output logic rst_status,
  output logic frame_err
);
  logic [1:0] hold_reg;
  logic open_reg;
  // ready stands high in reset, so the source must not trust it alone
  assign ready = reset | ~stall;
  assign rst_status = reset | (hold_reg != 2'h0);
  always @(posedge sys_clk) begin
    if (reset) begin
      hold_reg <= 2'h3;
      open_reg <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
      if (valid) begin
        if (first == open_reg) frame_err <= 1'b1;
        open_reg <= ~last;
      end
    end
  end
endmodule : sink_model
`default_nettype wire

// ===== pcie_tlp_tx_stream_sink_test.sv
// self-checking bench for the TLP transmit source
`timescale 1ns/1ps
`default_nettype none
module pcie_tlp_tx_stream_sink_test;
  import tlp_tx_pkg::*;
  localparam int CW = WORD_W + 5;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic wide_mode = 1'b1;
  logic lat_two = 1'b1;
  logic pkt_start = 1'b0;
  logic [LEN_W-1:0] pkt_beats = '0;
  logic pkt_last_half = 1'b0;
  logic avail_rnd = 1'b1;
  logic stall = 1'b0;
  logic beat_avail;
  logic [WORD_W-1:0] beat_data;
  logic [WORD_W-1:0] tx_word_bus;
  logic pkt_busy, beat_take, pkt_done, tx_accept_ok, core_reset_status;
  logic tx_first_beat, tx_last_beat, tx_beat_qualifier, tx_upper_half_unused;
  logic frame_err;
  logic [CW-1:0] seen_beat;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 9813;
  int sent = 0;
  int lens[6] = '{1, 2, 5, 1, 1, 3};
  logic [WORD_W-1:0] data_q[$];
  logic [CW-1:0] exp_q[$];
  always #5 sys_clk = ~sys_clk;
  // next beat is offered in the take cycle so it is never sent twice
  always @* begin
    beat_avail = avail_rnd && (sent + beat_take < data_q.size());
    beat_data = data_q[sent + beat_take];
  end
  assign seen_beat = {tx_word_bus, tx_first_beat, tx_last_beat,
                      tx_upper_half_unused, pkt_done, beat_take};
  tlp_tx_source i_dut (.sys_clk(sys_clk), .reset(reset),
    .wide_mode(wide_mode), .lat_two(lat_two), .pkt_start(pkt_start),
    .pkt_beats(pkt_beats), .pkt_last_half(pkt_last_half),
    .pkt_busy(pkt_busy), .beat_avail(beat_avail), .beat_data(beat_data),
    .beat_take(beat_take), .pkt_done(pkt_done),
    .tx_accept_ok(tx_accept_ok), .core_reset_status(core_reset_status),
    .tx_word_bus(tx_word_bus), .tx_first_beat(tx_first_beat),
    .tx_last_beat(tx_last_beat), .tx_beat_qualifier(tx_beat_qualifier),
    .tx_upper_half_unused(tx_upper_half_unused));
  sink_model i_sink (.sys_clk(sys_clk), .reset(reset), .stall(stall),
    .valid(tx_beat_qualifier), .first(tx_first_beat),
    .last(tx_last_beat), .ready(tx_accept_ok),
    .rst_status(core_reset_status), .frame_err(frame_err));
  task automatic check(input string nm, input logic [CW-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge sys_clk) begin
    avail_rnd <= ($random(seed) % 5) != 0;
    stall <= ($random(seed) % 3) == 0;
    if (beat_take === 1'b1) sent <= sent + 1;
    if (tx_beat_qualifier === 1'b1) begin
      if (exp_q.size() == 0) check("extra beat", 1, 0);
      else check("beat", seen_beat, exp_q.pop_front());
    end
  end
  task automatic wait_busy(input logic lvl);
    for (int k = 0; k < 300 && pkt_busy !== lvl; k++) @(posedge sys_clk);
    check("busy", pkt_busy, lvl);
  endtask : wait_busy
  task automatic do_reset;
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("holdoff", {tx_beat_qualifier, pkt_busy}, 2'b01);
  endtask : do_reset
  task automatic send_pkt(input int len, input logic half);
    logic [WORD_W-1:0] d;
    logic [WORD_W-1:0] m;
    // the narrow path forces the upper qword to zero
    m = wide_mode ? '1 : {{QWORD_W{1'b0}}, {QWORD_W{1'b1}}};
    for (int i = 0; i < len; i++) begin
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      data_q.push_back(d);
      exp_q.push_back({d & m, i == 0, i == len - 1,
        wide_mode & half & (i == len - 1), i == len - 1, 1'b1});
    end
    wait_busy(1'b0);
    pkt_start <= 1'b1;
    pkt_beats <= len[LEN_W-1:0];
    pkt_last_half <= half;
    wait_busy(1'b1);
    pkt_start <= 1'b0;
    wait_busy(1'b0);
  endtask : send_pkt
  initial begin
    do_reset();
    foreach (lens[j]) send_pkt(lens[j], ($random(seed) % 2) != 0);
    lat_two <= 1'b0;
    wide_mode <= 1'b0;
    do_reset();
    foreach (lens[j]) send_pkt(lens[j], 1'b1);
    pkt_beats <= '0;
    pkt_start <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pkt_start <= 1'b0;
    @(posedge sys_clk);
    check("zero length", pkt_busy, 0);
    repeat (10) @(posedge sys_clk);
    check("left", exp_q.size(), 0);
    check("frame", frame_err, 0);
    complete_run();
  end
  // a dozen short packets need a few hundred cycles; allow far more
  initial begin
    #500000;
    n_errors++;
    complete_run();
  end
endmodule : pcie_tlp_tx_stream_sink_test
`default_nettype wire
